/* File: logic/cmm_pkg.sv */
// Constants for the core data/program memory map block.
// Assumes a single core clock and a synchronous, active-low reset.
//
// Summary of operation
// RQ1 - Two 16-bit pointers reach data and program
// RQ2 - Program memory via pointer costs one cycle
// RQ3 - Pointers address general RAM as linear block
// RQ4 - Fifteen-bit counter over 32K 14-bit words
// RQ5 - Program addresses wrap inside implemented space
// RQ6 - Reset fetches 0000h, interrupt vectors 0004h
// RQ7 - Top 128 words form the endurance region
// RQ8 - Pointer high bit 7 selects program memory
// RQ9 - Program read returns low eight word bits
// RQ10 - Pointer writes never alter program memory
// RQ11 - Data memory is 32 banks of 128
// RQ12 - Bank: core, peripheral, general, common RAM
// RQ13 - Twelve-bit address: five bank, seven offset
// RQ14 - Direct accesses take bank from bank select
// RQ15 - Unimplemented data locations read as zero
// RQ16 - Same twelve core registers in every bank
// RQ17 - Flag-updating instruction discards arithmetic flag writes
// RQ18 - Expiry and sleep flags ignore all writes
// RQ19 - Clearing flags register sets zero, keeps rest
// RQ20 - Software alters flags only with neutral instructions
// RQ21 - Carry flags mean not-borrow during subtraction
// RQ22 - Borrow polarity inverted by two's complement add
// RQ23 - Nibble flag reflects carry out of bit 3
// RQ24 - Program pointer bits wrap within program space
// RQ25 - Core registers are one instance for all
package cmm_pkg;

  // ****************************************
  // Program space
  // ****************************************
  localparam int PC_W = 15;
  localparam int PM_W = 14;
  localparam logic [14:0] PM_LAST_SMALL = 15'h0fff;
  localparam logic [14:0] PM_LAST_BIG = 15'h1fff;
  localparam logic [14:0] HI_ENDUR_SPAN = 15'h007f;
  localparam logic [14:0] RESET_VEC = 15'h0000;
  localparam logic [14:0] INT_VEC = 15'h0004;

  // ****************************************
  // Data space
  // ****************************************
  localparam int BANKS = 32;
  localparam int BANK_BYTES = 128;
  localparam int GPR_PER_BANK = 80;
  localparam int RAM_BANKS = 6;
  localparam int RAM_SIZE = RAM_BANKS * GPR_PER_BANK;
  localparam int COMMON_SIZE = 16;
  localparam logic [6:0] PERIPH_FIRST = 7'h0c;
  localparam logic [6:0] RAM_FIRST = 7'h20;
  localparam logic [6:0] COMMON_FIRST = 7'h70;
  localparam int PTR_PROG_BIT = 15;
  localparam logic [2:0] PTR_LINEAR_SEL = 3'h2;

  // ****************************************
  // Core register offsets
  // ****************************************
  localparam logic [6:0] OFF_INDIRECT_DATA_0 = 7'h00;
  localparam logic [6:0] OFF_INDIRECT_DATA_1 = 7'h01;
  localparam logic [6:0] OFF_PROGRAM_COUNTER_LOW = 7'h02;
  localparam logic [6:0] OFF_STATUS_FLAGS = 7'h03;
  localparam logic [6:0] OFF_POINTER0_LOW = 7'h04;
  localparam logic [6:0] OFF_POINTER0_HIGH = 7'h05;
  localparam logic [6:0] OFF_POINTER1_LOW = 7'h06;
  localparam logic [6:0] OFF_POINTER1_HIGH = 7'h07;
  localparam logic [6:0] OFF_BANK_SELECT = 7'h08;
  localparam logic [6:0] OFF_WORKING_REGISTER = 7'h09;
  localparam logic [6:0] OFF_PROGRAM_COUNTER_LATCH_HIGH = 7'h0a;
  localparam logic [6:0] OFF_INTERRUPT_CONTROL = 7'h0b;

  // ****************************************
  // Flag register layout and resets
  // ****************************************
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_NIBBLE = 1;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_SLEEP = 3;
  localparam int FLAG_EXPIRY = 4;
  localparam logic [2:0] ARITH_RST = 3'h0;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [7:0] REG_RST = 8'h00;

  typedef enum logic [1:0] {
    OP_PASS,
    OP_ADD,
    OP_SUB,
    OP_CLEAR
  } cmm_alu_op_t;

endpackage : cmm_pkg

/* File: logic/cmm_alu_flags.sv */
// Arithmetic result and flag generation for one file operation.
// Assumes operands are stable for the cycle in which they are used.
`timescale 1ns/1ps
module cmm_alu_flags (
  // Operands
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  input wire cmm_pkg::cmm_alu_op_t i_op,
  // Results, flags ordered zero, nibble, carry
  output logic [7:0] o_res,
  output logic [2:0] o_flags,
  output logic [2:0] o_upd
);
  logic [7:0] b_eff;
  logic [8:0] sum;
  logic [4:0] nib;
  logic cin;

  always_comb begin
    cin = (i_op == cmm_pkg::OP_SUB);
    // Subtract as add of the complement, so carry reads as not-borrow
    b_eff = cin ? ~i_b : i_b; // see RQ22
    sum = {1'b0, i_a} + {1'b0, b_eff} + {8'h00, cin}; // see RQ21
    nib = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin}; // see RQ23
    unique case (i_op)
      cmm_pkg::OP_PASS: begin
        o_res = i_a;
        o_upd = 3'h0;
      end
      cmm_pkg::OP_ADD, cmm_pkg::OP_SUB: begin
        o_res = sum[7:0];
        o_upd = 3'h7;
      end
      cmm_pkg::OP_CLEAR: begin
        o_res = 8'h00;
        o_upd = 3'h4;
      end
    endcase
    o_flags = {(o_res == 8'h00), nib[4], sum[8]};
  end
endmodule : cmm_alu_flags

/* File: logic/cmm_prog_addr.sv */
// Program address wrap and endurance-region detect.
// Assumes the implemented size is fixed for the life of the part.
`timescale 1ns/1ps
module cmm_prog_addr (
  // Raw address and size select
  input wire logic [14:0] i_addr,
  input wire logic i_big,
  // Wrapped address and region flag
  output logic [14:0] o_addr,
  output logic o_hi_endur
);
  logic [14:0] last;

  always_comb begin
    last = i_big ? cmm_pkg::PM_LAST_BIG : cmm_pkg::PM_LAST_SMALL;
    o_addr = i_addr & last; // see RQ5
    o_hi_endur = ((o_addr | cmm_pkg::HI_ENDUR_SPAN) == last); // see RQ7
  end
endmodule : cmm_prog_addr

/* File: logic/cmm_core_map.sv */
// Core register file, data memory banking and indirect access.
// Assumes the CPU holds a request until it is taken and
// presents program words in the cycle the read strobe is high.
`timescale 1ns/1ps
module cmm_core_map #(
  parameter bit BIG_PM = 1'b0
) (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  // Fetch control
  input wire logic I_PC_INC,
  input wire logic I_INT_VEC,
  output logic [14:0] O_FETCH_ADDR,
  output logic O_FETCH_HI_ENDUR,
  // File access request
  input wire logic I_ACC_VLD,
  input wire logic I_ACC_WR,
  input wire logic [6:0] I_ACC_ADDR,
  input wire logic [7:0] I_ACC_WDATA,
  input wire logic [7:0] I_ACC_OPB,
  input wire cmm_pkg::cmm_alu_op_t I_ACC_OP,
  output logic O_ACC_BUSY,
  output logic O_ACC_DONE,
  output logic [7:0] O_ACC_RDATA,
  // Program memory data port
  output logic O_PM_RD,
  output logic [14:0] O_PM_ADDR,
  input wire logic [13:0] I_PM_DATA,
  // Power events
  input wire logic I_WDT_EXPIRE,
  input wire logic I_SLEEP,
  input wire logic I_CLRWDT,
  // Core state
  output logic [7:0] O_FLAGS,
  output logic [7:0] O_WORK
);

  typedef enum {
    ST_IDLE,
    ST_PROG_WAIT
  } cmm_state_t;

  typedef enum {
    K_NONE,
    K_CORE,
    K_RAM,
    K_COMMON,
    K_PROG
  } cmm_kind_t;

  // ****************************************
  // State
  // ****************************************
  cmm_state_t state_q;
  logic [15:0] ptr0_q;
  logic [15:0] ptr1_q;
  logic [4:0] bank_q;
  logic [7:0] work_q;
  logic [6:0] pc_latch_q;
  logic [7:0] irq_ctl_q;
  logic [2:0] arith_q;
  logic expiry_q;
  logic sleep_q;
  logic [14:0] pc_q;
  logic [14:0] pc_d;
  logic [14:0] pc_wrap;
  logic pc_hi_endur;
  logic fetch_hi_endur_q;
  logic busy_q;
  logic done_q;
  logic [7:0] rdata_q;
  logic pm_rd_q;
  logic [14:0] pm_addr_q;
  logic [14:0] ptr_prog;
  logic [7:0] ram [0:cmm_pkg::RAM_SIZE-1];
  logic [7:0] common [0:cmm_pkg::COMMON_SIZE-1];

  // ****************************************
  // Decode
  // ****************************************
  logic taken;
  logic is_ind;
  logic [15:0] ptr;
  logic [11:0] daddr;
  logic [6:0] doff;
  logic [4:0] dbank;
  cmm_kind_t kind;
  logic [8:0] ram_idx;
  logic [3:0] com_idx;
  logic [7:0] res;
  logic [2:0] alu_flags;
  logic [2:0] alu_upd;
  logic wr_core;
  logic [7:0] core_rd;
  logic [7:0] rd_val;
  logic [7:0] flags_rd;

  assign taken = I_ACC_VLD && !busy_q;
  // Indirect data registers route the access through a pointer
  assign is_ind = (I_ACC_ADDR == cmm_pkg::OFF_INDIRECT_DATA_0) ||
                  (I_ACC_ADDR == cmm_pkg::OFF_INDIRECT_DATA_1);
  assign ptr = (I_ACC_ADDR == cmm_pkg::OFF_INDIRECT_DATA_1) ? ptr1_q : ptr0_q; // see RQ1
  assign daddr = is_ind ? ptr[11:0] : {bank_q, I_ACC_ADDR}; // see RQ14
  assign doff = daddr[6:0]; // see RQ13
  assign dbank = daddr[11:7];
  assign flags_rd = {3'h0, expiry_q, sleep_q, arith_q};

  always_comb begin
    kind = K_NONE;
    ram_idx = 9'h000;
    com_idx = doff[3:0];
    if (is_ind && ptr[cmm_pkg::PTR_PROG_BIT]) begin
      kind = K_PROG; // see RQ8
    end else if (is_ind && ptr[14:12] == cmm_pkg::PTR_LINEAR_SEL) begin
      // Linear window packs every bank's RAM end to end
      if (int'(ptr[11:0]) < cmm_pkg::RAM_SIZE) begin
        kind = K_RAM; // see RQ3
        ram_idx = ptr[8:0];
      end
    end else if (!is_ind || ptr[14:12] == 3'h0) begin
      if (doff < cmm_pkg::PERIPH_FIRST) begin
        // Pointer aimed at an indirect data register reads as zero
        if (!(is_ind && doff <= cmm_pkg::OFF_INDIRECT_DATA_1)) begin
          kind = K_CORE; // see RQ16
        end
      end else if (doff >= cmm_pkg::COMMON_FIRST) begin
        kind = K_COMMON; // see RQ12
      end else if (doff >= cmm_pkg::RAM_FIRST && int'(dbank) < cmm_pkg::RAM_BANKS) begin
        kind = K_RAM; // see RQ11
        ram_idx = 9'(int'(dbank) * cmm_pkg::GPR_PER_BANK + int'(doff - cmm_pkg::RAM_FIRST));
      end
    end
  end

  assign wr_core = taken && I_ACC_WR && (kind == K_CORE);

  cmm_alu_flags u_alu (
    .i_a(I_ACC_WDATA),
    .i_b(I_ACC_OPB),
    .i_op(I_ACC_OP),
    .o_res(res),
    .o_flags(alu_flags),
    .o_upd(alu_upd)
  );

  // ****************************************
  // Core register read
  // ****************************************
  always_comb begin
    unique case (doff)
      cmm_pkg::OFF_PROGRAM_COUNTER_LOW: core_rd = pc_q[7:0];
      cmm_pkg::OFF_STATUS_FLAGS: core_rd = flags_rd;
      cmm_pkg::OFF_POINTER0_LOW: core_rd = ptr0_q[7:0];
      cmm_pkg::OFF_POINTER0_HIGH: core_rd = ptr0_q[15:8];
      cmm_pkg::OFF_POINTER1_LOW: core_rd = ptr1_q[7:0];
      cmm_pkg::OFF_POINTER1_HIGH: core_rd = ptr1_q[15:8];
      cmm_pkg::OFF_BANK_SELECT: core_rd = {3'h0, bank_q};
      cmm_pkg::OFF_WORKING_REGISTER: core_rd = work_q;
      cmm_pkg::OFF_PROGRAM_COUNTER_LATCH_HIGH: core_rd = {1'b0, pc_latch_q};
      cmm_pkg::OFF_INTERRUPT_CONTROL: core_rd = irq_ctl_q;
      default: core_rd = 8'h00;
    endcase
  end

  always_comb begin
    unique case (kind)
      K_CORE: rd_val = core_rd;
      K_RAM: rd_val = ram[ram_idx];
      K_COMMON: rd_val = common[com_idx];
      default: rd_val = 8'h00; // see RQ15
    endcase
  end

  // ****************************************
  // Pointers and plain core registers
  // ****************************************
  // One flop per register, whatever bank the access came through
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      ptr0_q <= cmm_pkg::PTR_RST;
      ptr1_q <= cmm_pkg::PTR_RST;
      bank_q <= 5'h00;
      work_q <= cmm_pkg::REG_RST;
      pc_latch_q <= 7'h00;
      irq_ctl_q <= cmm_pkg::REG_RST;
    end else if (wr_core) begin // see RQ25
      unique case (doff)
        cmm_pkg::OFF_POINTER0_LOW: ptr0_q[7:0] <= res;
        cmm_pkg::OFF_POINTER0_HIGH: ptr0_q[15:8] <= res;
        cmm_pkg::OFF_POINTER1_LOW: ptr1_q[7:0] <= res;
        cmm_pkg::OFF_POINTER1_HIGH: ptr1_q[15:8] <= res;
        cmm_pkg::OFF_BANK_SELECT: bank_q <= res[4:0]; // see RQ14
        cmm_pkg::OFF_WORKING_REGISTER: work_q <= res;
        cmm_pkg::OFF_PROGRAM_COUNTER_LATCH_HIGH: pc_latch_q <= res[6:0];
        cmm_pkg::OFF_INTERRUPT_CONTROL: irq_ctl_q <= res;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Flag register
  // ****************************************
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      arith_q <= cmm_pkg::ARITH_RST;
    end else if (taken) begin
      for (int i = 0; i < 3; i++) begin
        if (alu_upd[i]) begin
          arith_q[i] <= alu_flags[i]; // see RQ19
        end else if (wr_core && doff == cmm_pkg::OFF_STATUS_FLAGS && alu_upd == 3'h0) begin
          // Any flag-setting op blocks all three written bits
          arith_q[i] <= res[i]; // see RQ17
        end
      end
    end
  end

  // Written data never reaches these two; events only
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      expiry_q <= 1'b1;
      sleep_q <= 1'b1;
    end else begin
      if (I_CLRWDT) begin
        sleep_q <= 1'b1; // see RQ18
      end else if (I_SLEEP) begin
        sleep_q <= 1'b0;
      end
      if (I_WDT_EXPIRE) begin
        expiry_q <= 1'b0;
      end else if (I_CLRWDT || I_SLEEP) begin
        expiry_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Program counter
  // ****************************************
  always_comb begin
    pc_d = pc_q + 15'h0001;
    if (I_INT_VEC) begin
      pc_d = cmm_pkg::INT_VEC; // see RQ6
    end else if (wr_core && doff == cmm_pkg::OFF_PROGRAM_COUNTER_LOW) begin
      pc_d = {pc_latch_q, res}; // see RQ4
    end else if (!I_PC_INC) begin
      pc_d = pc_q;
    end
  end

  cmm_prog_addr u_pc_wrap (
    .i_addr(pc_d),
    .i_big(BIG_PM),
    .o_addr(pc_wrap),
    .o_hi_endur(pc_hi_endur)
  );

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      pc_q <= cmm_pkg::RESET_VEC; // see RQ6
      fetch_hi_endur_q <= 1'b0;
    end else begin
      pc_q <= pc_wrap; // see RQ5
      fetch_hi_endur_q <= pc_hi_endur;
    end
  end

  // ****************************************
  // Data RAM
  // ****************************************
  // Contents are not reset; software owns initialisation
  always_ff @(posedge I_REF_CLK) begin
    if (taken && I_ACC_WR) begin
      if (kind == K_RAM) begin
        ram[ram_idx] <= res;
      end
      if (kind == K_COMMON) begin
        common[com_idx] <= res;
      end
    end
  end

  // ****************************************
  // Access sequencing
  // ****************************************
  cmm_prog_addr u_ptr_wrap (
    .i_addr(ptr[14:0]),
    .i_big(BIG_PM),
    .o_addr(ptr_prog),
    .o_hi_endur()
  );

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
      pm_rd_q <= 1'b0;
      pm_addr_q <= cmm_pkg::RESET_VEC;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          done_q <= 1'b0;
          if (taken) begin
            if (kind == K_PROG && !I_ACC_WR) begin
              // Word must be fetched first: one extra cycle
              state_q <= ST_PROG_WAIT; // see RQ2
              busy_q <= 1'b1;
              pm_rd_q <= 1'b1;
              pm_addr_q <= ptr_prog; // see RQ24
            end else begin
              // Program writes complete but change nothing
              done_q <= 1'b1; // see RQ10
              rdata_q <= I_ACC_WR ? 8'h00 : rd_val;
            end
          end
        end
        ST_PROG_WAIT: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
          pm_rd_q <= 1'b0;
          done_q <= 1'b1;
          rdata_q <= I_PM_DATA[7:0]; // see RQ9
        end
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign O_FETCH_ADDR = pc_q;
  assign O_FETCH_HI_ENDUR = fetch_hi_endur_q;
  assign O_ACC_BUSY = busy_q;
  assign O_ACC_DONE = done_q;
  assign O_ACC_RDATA = rdata_q;
  assign O_PM_RD = pm_rd_q;
  assign O_PM_ADDR = pm_addr_q;
  assign O_FLAGS = {3'h0, expiry_q, sleep_q, arith_q};
  assign O_WORK = work_q;

endmodule : cmm_core_map

/* File: testbench/cmm_core_map_asserts.sv */
// Port-level checker for the core memory map block.
// Assumes binding to cmm_core_map with its BIG_PM value.
`timescale 1ns/1ps
module cmm_core_map_asserts #(
  parameter bit BIG_PM = 1'b0
) (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  // Fetch
  input wire logic I_PC_INC,
  input wire logic I_INT_VEC,
  input wire logic [14:0] O_FETCH_ADDR,
  input wire logic O_FETCH_HI_ENDUR,
  // File access
  input wire logic I_ACC_VLD,
  input wire logic I_ACC_WR,
  input wire logic [6:0] I_ACC_ADDR,
  input wire cmm_pkg::cmm_alu_op_t I_ACC_OP,
  input wire logic O_ACC_BUSY,
  input wire logic O_ACC_DONE,
  input wire logic [7:0] O_ACC_RDATA,
  // Program memory and events
  input wire logic O_PM_RD,
  input wire logic [14:0] O_PM_ADDR,
  input wire logic [13:0] I_PM_DATA,
  input wire logic I_WDT_EXPIRE,
  input wire logic I_SLEEP,
  input wire logic I_CLRWDT,
  input wire logic [7:0] O_FLAGS
);
  // ********
  // Properties
  // ********
  localparam logic [14:0] LAST = BIG_PM ? 15'h1fff : 15'h0fff;
  logic [7:0] pm_lo;
  logic [1:0] pwr_flags;
  logic pcl_wr;
  assign pm_lo = I_PM_DATA[7:0];
  assign pwr_flags = O_FLAGS[4:3];
  // Pointer writes may also land on the low counter byte
  assign pcl_wr = I_ACC_VLD && I_ACC_WR && !O_ACC_BUSY && (I_ACC_ADDR <= 7'h02);
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_B);
  property p_answer; I_ACC_VLD && !O_ACC_BUSY |=> O_ACC_DONE || O_PM_RD; endproperty
  a_answer: assert property (p_answer) else $error("access not answered");
  property p_prog_done; O_PM_RD |=> O_ACC_DONE && !O_ACC_BUSY && !O_PM_RD; endproperty
  a_prog_done: assert property (p_prog_done) else $error("program read not finished");
  property p_prog_busy; O_PM_RD |-> O_ACC_BUSY; endproperty
  a_prog_busy: assert property (p_prog_busy) else $error("busy low in program read");
  property p_prog_data; O_PM_RD |=> O_ACC_RDATA == $past(pm_lo); endproperty
  a_prog_data: assert property (p_prog_data) else $error("program byte wrong");
  property p_pm_wrap; O_PM_RD |-> O_PM_ADDR <= LAST; endproperty
  a_pm_wrap: assert property (p_pm_wrap) else $error("program address not wrapped");
  property p_pc_inc; I_PC_INC && !I_INT_VEC && !pcl_wr |=> O_FETCH_ADDR == (($past(O_FETCH_ADDR) + 15'h0001) & LAST);
  endproperty
  a_pc_inc: assert property (p_pc_inc) else $error("counter step wrong");
  property p_int_vec; I_INT_VEC |=> O_FETCH_ADDR == 15'h0004; endproperty
  a_int_vec: assert property (p_int_vec) else $error("interrupt vector wrong");
  property p_endur; O_FETCH_HI_ENDUR == (O_FETCH_ADDR >= LAST - 15'h007f); endproperty
  a_endur: assert property (p_endur) else $error("endurance flag wrong");
  property p_upper0; O_FLAGS[7:5] == 3'h0; endproperty
  a_upper0: assert property (p_upper0) else $error("upper flag bits set");
  property p_clear; I_ACC_VLD && I_ACC_WR && !O_ACC_BUSY && I_ACC_ADDR == 7'h03 && I_ACC_OP == cmm_pkg::OP_CLEAR
    |=> O_FLAGS[7:5] == 3'h0 && O_FLAGS[2] && O_FLAGS[1:0] == $past(O_FLAGS[1:0]); endproperty
  a_clear: assert property (p_clear) else $error("clear of flags wrong");
  property p_pwr_hold; !(I_WDT_EXPIRE || I_SLEEP || I_CLRWDT) |=> $stable(pwr_flags); endproperty
  a_pwr_hold: assert property (p_pwr_hold) else $error("power flags changed");
  property p_sleep; I_SLEEP && !I_CLRWDT && !I_WDT_EXPIRE |=> pwr_flags == 2'h2; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
endmodule : cmm_core_map_asserts

bind cmm_core_map cmm_core_map_asserts #(.BIG_PM(BIG_PM)) cmm_core_map_asserts_i (
  .I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B), .I_PC_INC(I_PC_INC), .I_INT_VEC(I_INT_VEC),
  .O_FETCH_ADDR(O_FETCH_ADDR), .O_FETCH_HI_ENDUR(O_FETCH_HI_ENDUR), .I_ACC_VLD(I_ACC_VLD),
  .I_ACC_WR(I_ACC_WR), .I_ACC_ADDR(I_ACC_ADDR), .I_ACC_OP(I_ACC_OP),
  .O_ACC_BUSY(O_ACC_BUSY), .O_ACC_DONE(O_ACC_DONE),
  .O_ACC_RDATA(O_ACC_RDATA), .O_PM_RD(O_PM_RD), .O_PM_ADDR(O_PM_ADDR), .I_PM_DATA(I_PM_DATA),
  .I_WDT_EXPIRE(I_WDT_EXPIRE), .I_SLEEP(I_SLEEP), .I_CLRWDT(I_CLRWDT), .O_FLAGS(O_FLAGS)
);

/* File: testbench/cmm_pm_model.sv */
// Program memory seen from the core map block.
// Assumes a word is wanted only while the read strobe is high.
`timescale 1ns/1ps
module cmm_pm_model (
  // Clock
  input wire logic i_clk,
  // Read port
  input wire logic i_rd,
  input wire logic [14:0] i_addr,
  output logic [13:0] o_data
);
  logic [13:0] last_q = 14'h0000;
  logic [13:0] word;
  assign word = {i_addr[13:8], i_addr[7:0] ^ 8'h5a};
  // Idle bus shows the inverse of the last word, never a stale copy
  assign o_data = i_rd ? word : ~last_q;
  always_ff @(posedge i_clk) begin
    if (i_rd) begin
      last_q <= word;
    end
  end
endmodule : cmm_pm_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the core memory map block.
// Assumes the small program space and the program memory model.
`timescale 1ns/1ps
module tb_top;
  // ********
  // Stimulus and checks
  // ********
  logic ref_clk = 1'b0, rst_b = 1'b0, pc_inc = 1'b0, int_vec = 1'b0, vld = 1'b0, wr = 1'b0;
  logic wdt = 1'b0, slp = 1'b0, clrwdt = 1'b0, hi_endur, busy, done, pm_rd;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00, opb = 8'h00, rdata, flags, work, r;
  logic [14:0] fetch_addr, pm_addr;
  logic [13:0] pm_data;
  cmm_pkg::cmm_alu_op_t op = cmm_pkg::OP_PASS;
  int bad_count = 0, cmp_count = 0, n;

  always #20 ref_clk = ~ref_clk;

  cmm_core_map #(.BIG_PM(1'b0)) cmm_core_map_i (
    .I_REF_CLK(ref_clk), .I_RST_B(rst_b), .I_PC_INC(pc_inc), .I_INT_VEC(int_vec),
    .O_FETCH_ADDR(fetch_addr), .O_FETCH_HI_ENDUR(hi_endur), .I_ACC_VLD(vld), .I_ACC_WR(wr),
    .I_ACC_ADDR(addr), .I_ACC_WDATA(wdata), .I_ACC_OPB(opb), .I_ACC_OP(op), .O_ACC_BUSY(busy),
    .O_ACC_DONE(done), .O_ACC_RDATA(rdata), .O_PM_RD(pm_rd), .O_PM_ADDR(pm_addr), .I_PM_DATA(pm_data),
    .I_WDT_EXPIRE(wdt), .I_SLEEP(slp), .I_CLRWDT(clrwdt), .O_FLAGS(flags), .O_WORK(work)
  );
  cmm_pm_model cmm_pm_model_i (.i_clk(ref_clk), .i_rd(pm_rd), .i_addr(pm_addr), .o_data(pm_data));

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte

  task automatic chk_addr(input string nm, input logic [14:0] e, input logic [14:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_addr

  // One request, held over one taking edge; n counts extra wait cycles
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d, input cmm_pkg::cmm_alu_op_t o,
                     input logic [7:0] b);
    vld = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    op = o;
    opb = b;
    @(negedge ref_clk);
    vld = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    chk_byte("done", 8'h01, {7'h00, done});
    r = rdata;
    @(negedge ref_clk);
  endtask : acc

  task automatic wrt(input logic [6:0] a, input logic [7:0] d);
    acc(1'b1, a, d, cmm_pkg::OP_PASS, 8'h00);
  endtask : wrt

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e, input string nm);
    acc(1'b0, a, 8'h00, cmm_pkg::OP_PASS, 8'h00);
    chk_byte(nm, e, r);
  endtask : rd_chk

  // Event pulse given as {expiry, sleep, clear}
  task automatic ev(input logic [2:0] e, input logic [7:0] x);
    {wdt, slp, clrwdt} = e;
    @(negedge ref_clk);
    {wdt, slp, clrwdt} = 3'h0;
    @(negedge ref_clk);
    chk_byte("flags_event", x, flags);
  endtask : ev

  task automatic step(input logic iv);
    pc_inc = !iv;
    int_vec = iv;
    @(negedge ref_clk);
    pc_inc = 1'b0;
    int_vec = 1'b0;
    @(negedge ref_clk);
    @(negedge ref_clk);
  endtask : step

  task automatic t_reset();
    rst_b = 1'b0;
    repeat (12) @(negedge ref_clk);
    rst_b = 1'b1;
    @(negedge ref_clk);
    chk_byte("flags_rst", 8'h18, flags);
    chk_byte("work_rst", 8'h00, work);
    chk_addr("fetch_rst", 15'h0000, fetch_addr);
  endtask : t_reset

  task automatic t_core();
    wrt(7'h09, 8'h5a);
    wrt(7'h08, 8'h03);
    rd_chk(7'h09, 8'h5a, "work_mirror");
    rd_chk(7'h08, 8'h03, "bank_sel");
    chk_byte("work_port", 8'h5a, work);
    rd_chk(7'h0c, 8'h00, "periph");
  endtask : t_core

  task automatic t_bank();
    wrt(7'h20, 8'ha1);
    wrt(7'h70, 8'h77);
    wrt(7'h08, 8'h00);
    wrt(7'h20, 8'hb2);
    rd_chk(7'h70, 8'h77, "common");
    wrt(7'h08, 8'h03);
    rd_chk(7'h20, 8'ha1, "bank3_ram");
    wrt(7'h08, 8'h1f);
    rd_chk(7'h20, 8'h00, "bank31_ram");
  endtask : t_bank

  task automatic t_indirect();
    wrt(7'h05, 8'h01);
    wrt(7'h04, 8'ha0);
    rd_chk(7'h00, 8'ha1, "ind_banked");
    wrt(7'h07, 8'h20);
    wrt(7'h06, 8'h50);
    wrt(7'h01, 8'hc3);
    wrt(7'h08, 8'h01);
    rd_chk(7'h20, 8'hc3, "linear");
  endtask : t_indirect

  task automatic t_prog();
    wrt(7'h05, 8'h9f);
    wrt(7'h04, 8'h85);
    rd_chk(7'h00, 8'hdf, "pm_byte");
    chk_byte("pm_wait", 8'h01, 8'(n));
    chk_addr("pm_addr", 15'h0f85, pm_addr);
    wrt(7'h00, 8'h11);
    rd_chk(7'h00, 8'hdf, "pm_after_wr");
  endtask : t_prog

  task automatic t_flags();
    acc(1'b1, 7'h03, 8'h0f, cmm_pkg::OP_ADD, 8'h01);
    chk_byte("flags_add", 8'h1a, flags);
    acc(1'b1, 7'h09, 8'h10, cmm_pkg::OP_SUB, 8'h01);
    chk_byte("flags_sub", 8'h19, flags);
    chk_byte("work_sub", 8'h0f, work);
    wrt(7'h03, 8'hff);
    chk_byte("flags_wr", 8'h1f, flags);
    acc(1'b1, 7'h09, 8'h01, cmm_pkg::OP_SUB, 8'h02);
    chk_byte("flags_borrow", 8'h18, flags);
    acc(1'b1, 7'h03, 8'h00, cmm_pkg::OP_CLEAR, 8'h00);
    chk_byte("flags_clr", 8'h1c, flags);
    ev(3'h2, 8'h14);
    ev(3'h4, 8'h04);
    ev(3'h1, 8'h1c);
    wrt(7'h03, 8'h00);
    chk_byte("flags_wr0", 8'h18, flags);
  endtask : t_flags

  task automatic t_fetch();
    wrt(7'h0a, 8'h0f);
    wrt(7'h02, 8'hfe);
    chk_addr("pc_load", 15'h0ffe, fetch_addr);
    chk_byte("endur_top", 8'h01, {7'h00, hi_endur});
    step(1'b0);
    step(1'b0);
    chk_addr("pc_wrap", 15'h0000, fetch_addr);
    chk_byte("endur_low", 8'h00, {7'h00, hi_endur});
    step(1'b1);
    chk_addr("int_vec", 15'h0004, fetch_addr);
  endtask : t_fetch

  initial begin
    t_reset();
    t_core();
    t_bank();
    t_indirect();
    t_prog();
    t_flags();
    t_fetch();
    t_reset();
    results();
  end

  // Whole run is a little over a hundred cycles; this cuts a hang short
  initial begin
    repeat (3000) @(posedge ref_clk);
    bad_count++;
    results();
  end
endmodule : tb_top
